// [core/csr_regs.svh]
`ifndef CSR_REGS_SVH
`define CSR_REGS_SVH

`define CSR_ADDR_VBAT        8'h12
`define CSR_ADDR_FAST        8'h13
`define CSR_ADDR_PCHG        8'h14
`define CSR_ADDR_TERM        8'h15
`define CSR_ADDR_PROT        8'h16
`define CSR_RST_VBAT         8'h3C
`define CSR_RST_FAST         8'h08
`define CSR_RST_PCHG         8'h02
`define CSR_RST_TERM         8'h14
`define CSR_RST_PROT         8'h00
`define CSR_NUM_REGS         5
`define CSR_VBAT_BASE_MV     16'hE10
`define CSR_VBAT_STEP_MV     16'h000A
`define CSR_VBAT_MAX_MV      16'h11F8
`define CSR_VBAT_MAX_CODE    7'h64
`define CSR_STEP_LO_UA       20'h004E2
`define CSR_STEP_HI_UA       20'h009C4
`define CSR_LOWV_30_MV       16'h0BB8
`define CSR_LOWV_28_MV       16'h0AF0
`define CSR_UV_30_MV         16'h0BB8
`define CSR_UV_28_MV         16'h0AF0
`define CSR_UV_26_MV         16'h0A28
`define CSR_UV_24_MV         16'h0960
`define CSR_UV_22_MV         16'h0898
`define CSR_OCP_1200_MA      16'h04B0
`define CSR_OCP_1500_MA      16'h05DC
// Serial bus address of the port; value is arbitrary
`define CSR_DEV_ADDR         7'h35
`define CSR_RNW_BIT          0
`define CSR_GLITCH_LEN       2

`endif

// [core/csr_pkg.sv]
`default_nettype none
package csr_pkg;
	typedef enum logic [2:0] {
		CSR_IDLE  = 3'h0,
		CSR_DADDR = 3'h1,
		CSR_RADDR = 3'h2,
		CSR_WDATA = 3'h3,
		CSR_RDATA = 3'h4,
		CSR_ACK   = 3'h5,
		CSR_RACK  = 3'h6,
		CSR_SKIP  = 3'h7
	} csr_state_e;
	typedef logic [7:0] csr_byte_t;
endpackage
`default_nettype wire

// [core/csr_bus_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface csr_bus_if;
	logic                wr_en;
	logic [7:0]          addr;
	csr_pkg::csr_byte_t  wdata;
	csr_pkg::csr_byte_t  rdata;
	modport ctrl (output wr_en, output addr, output wdata, input rdata);
	modport bank (input wr_en, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// [core/csr_bank.sv]
`timescale 1ns/100ps
`default_nettype none
`include "csr_regs.svh"
module csr_bank (
	input  wire logic   clk_i,
	input  wire logic   rst_n_i,
	csr_bus_if.bank     bus,
	output logic [7:0]  vbat_o,
	output logic [7:0]  fast_o,
	output logic [7:0]  pchg_o,
	output logic [7:0]  term_o,
	output logic [7:0]  prot_o
);
	logic [7:0] regs      [`CSR_NUM_REGS];
	logic [7:0] next_regs [`CSR_NUM_REGS];
	logic [7:0] rdata;
	logic [7:0] next_rdata;

	always_comb begin
		next_regs = regs;
		next_rdata = 8'h00;
		unique case (bus.addr)
			`CSR_ADDR_VBAT: next_rdata = regs[0];
			`CSR_ADDR_FAST: next_rdata = regs[1];
			`CSR_ADDR_PCHG: next_rdata = regs[2];
			`CSR_ADDR_TERM: next_rdata = regs[3];
			`CSR_ADDR_PROT: next_rdata = regs[4];
			default:        next_rdata = 8'h00;
		endcase
		if (bus.wr_en) begin
			unique case (bus.addr)
				`CSR_ADDR_VBAT: begin
					// Saturate above 4.6 V; reserved bit 7 kept as storage
					next_regs[0] = {bus.wdata[7], (bus.wdata[6:0] > `CSR_VBAT_MAX_CODE) ?
						`CSR_VBAT_MAX_CODE : bus.wdata[6:0]};
				end
				`CSR_ADDR_FAST: next_regs[1] = bus.wdata;
				`CSR_ADDR_PCHG: next_regs[2] = bus.wdata;
				`CSR_ADDR_TERM: next_regs[3] = bus.wdata;
				`CSR_ADDR_PROT: next_regs[4] = bus.wdata;
				default: next_regs = regs;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			regs[0] <= `CSR_RST_VBAT;
			regs[1] <= `CSR_RST_FAST;
			regs[2] <= `CSR_RST_PCHG;
			regs[3] <= `CSR_RST_TERM;
			regs[4] <= `CSR_RST_PROT;
			rdata   <= 8'h00;
		end else begin
			regs  <= next_regs;
			rdata <= next_rdata;
		end
	end

	assign bus.rdata = rdata;
	assign vbat_o    = regs[0];
	assign fast_o    = regs[1];
	assign pchg_o    = regs[2];
	assign term_o    = regs[3];
	assign prot_o    = regs[4];
endmodule
`default_nettype wire

// [core/csr_setpoints.sv]
// Operation
// - Regulation target equals 3.6 V plus seven-bit code times 10 mV.
// - Written voltage codes above 4.6 V are stored as the 4.6 V code.
// - Fast current is eight-bit code times 1.25 mA or 2.5 mA step.
// - Pre-charge register bit 7 selects 1.25 mA (0) or 2.5 mA (1) step.
// - Pre-charge current is five-bit code times the selected step.
// - Termination current is code percent of fast current, 1 to 31 percent.
// - Termination bit 0 set suppresses termination; clear applies it.
// - Pre-charge exit threshold is 3.0 V when select is 0, else 2.8 V.
// - Over-current limit 1200 mA, 1500 mA, or disabled for codes 10, 11.
// - Undervolt codes 0-2 give 3.0 V, then 2.8 to 2.2 V, 7 disables.
// - Reset loads 0x3C voltage, 0x08 fast current, 0x02 pre-charge.
`timescale 1ns/100ps
`default_nettype none
`include "csr_regs.svh"
module csr_setpoints (
	input  wire logic   REF_CLK_I,
	input  wire logic   RST_N_I,
	input  wire logic   SCL_I,
	input  wire logic   SDA_I,
	output logic        SDA_O,
	output logic        SDA_OE_O,
	output logic [15:0] CHARGE_TARGET_VOLTAGE_MV_O,
	output logic [19:0] PROGRAMMED_FAST_CURRENT_UA_O,
	output logic [19:0] PRECHARGE_CURRENT_UA_O,
	output logic [4:0]  TERMINATION_PERCENT_CODE_O,
	output logic [27:0] TERMINATION_CURRENT_UA_X100_O,
	output logic        TERMINATION_ENABLE_O,
	output logic [15:0] PRECHARGE_EXIT_MV_O,
	output logic [15:0] OVERCURRENT_LIMIT_MA_O,
	output logic        OVERCURRENT_ENABLE_O,
	output logic [15:0] UNDERVOLT_MV_O,
	output logic        UNDERVOLT_ENABLE_O
);
	csr_bus_if bus ();
	logic [7:0] vbat;
	logic [7:0] fast;
	logic [7:0] pchg;
	logic [7:0] term;
	logic [7:0] prot;

	csr_bank u_bank (
		.clk_i   (REF_CLK_I),
		.rst_n_i (RST_N_I),
		.bus     (bus),
		.vbat_o  (vbat),
		.fast_o  (fast),
		.pchg_o  (pchg),
		.term_o  (term),
		.prot_o  (prot)
	);

	function automatic logic [19:0] csr_current(input logic [7:0] code, input logic hi);
		csr_current = 20'(code) * (hi ? `CSR_STEP_HI_UA : `CSR_STEP_LO_UA);
	endfunction

	// Pin synchronisers, then edge/condition detect on the second stage
	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	logic       scl_d;
	logic       sda_d;
	always_ff @(posedge REF_CLK_I) begin
		if (!RST_N_I) begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
			scl_d    <= 1'b1;
			sda_d    <= 1'b1;
		end else begin
			scl_sync <= {scl_sync[0], SCL_I};
			sda_sync <= {sda_sync[0], SDA_I};
			scl_d    <= scl_sync[1];
			sda_d    <= sda_sync[1];
		end
	end
	wire scl      = scl_sync[1];
	wire sda      = sda_sync[1];
	wire scl_rise = scl & ~scl_d;
	wire scl_fall = ~scl & scl_d;
	wire start_c  = scl & scl_d & sda_d & ~sda;
	wire stop_c   = scl & scl_d & ~sda_d & sda;

	csr_pkg::csr_state_e state;
	csr_pkg::csr_state_e next_state;
	csr_pkg::csr_state_e after_ack;
	csr_pkg::csr_state_e next_after_ack;
	logic [3:0] bitcnt;
	logic [3:0] next_bitcnt;
	logic [7:0] shreg;
	logic [7:0] next_shreg;
	logic [7:0] ptr;
	logic [7:0] next_ptr;
	logic       sda_oe;
	logic       next_sda_oe;
	logic       wr_en;
	logic       next_wr_en;

	always_comb begin
		next_state     = state;
		next_after_ack = after_ack;
		next_bitcnt    = bitcnt;
		next_shreg     = shreg;
		next_ptr       = ptr;
		next_sda_oe    = sda_oe;
		next_wr_en     = 1'b0;
		if (start_c) begin
			next_state  = csr_pkg::CSR_DADDR;
			next_bitcnt = 4'h0;
			next_sda_oe = 1'b0;
		end else if (stop_c) begin
			next_state  = csr_pkg::CSR_IDLE;
			next_sda_oe = 1'b0;
		end else begin
			unique case (state)
				csr_pkg::CSR_IDLE, csr_pkg::CSR_SKIP: next_sda_oe = 1'b0;
				csr_pkg::CSR_DADDR, csr_pkg::CSR_RADDR, csr_pkg::CSR_WDATA: begin
					if (scl_rise) begin
						next_shreg  = {shreg[6:0], sda};
						next_bitcnt = bitcnt + 4'h1;
					end
					if (scl_fall && bitcnt == 4'h8) begin
						next_bitcnt = 4'h0;
						next_sda_oe = 1'b1;
						next_state  = csr_pkg::CSR_ACK;
						if (state == csr_pkg::CSR_DADDR) begin
							if (shreg[7:1] != `CSR_DEV_ADDR) begin
								next_sda_oe = 1'b0;
								next_state  = csr_pkg::CSR_SKIP;
							end else if (shreg[`CSR_RNW_BIT]) begin
								next_after_ack = csr_pkg::CSR_RDATA;
							end else begin
								next_after_ack = csr_pkg::CSR_RADDR;
							end
						end else if (state == csr_pkg::CSR_RADDR) begin
							next_ptr       = shreg;
							next_after_ack = csr_pkg::CSR_WDATA;
						end else begin
							next_wr_en     = 1'b1;
							next_after_ack = csr_pkg::CSR_WDATA;
						end
					end
				end
				csr_pkg::CSR_ACK: begin
					if (scl_fall) begin
						next_state  = after_ack;
						next_sda_oe = (after_ack == csr_pkg::CSR_RDATA) & ~bus.rdata[7];
						next_shreg  = {bus.rdata[6:0], 1'b1};
						if (next_wr_en == 1'b0 && after_ack == csr_pkg::CSR_WDATA &&
							bitcnt == 4'h0)
							next_ptr = ptr;
					end
				end
				csr_pkg::CSR_RDATA: begin
					if (scl_fall) begin
						next_bitcnt = bitcnt + 4'h1;
						if (bitcnt == 4'h7) begin
							next_sda_oe = 1'b0;
							next_state  = csr_pkg::CSR_RACK;
							next_ptr    = ptr + 8'h01;
						end else begin
							next_sda_oe = ~shreg[7];
							next_shreg  = {shreg[6:0], 1'b1};
						end
					end
				end
				csr_pkg::CSR_RACK: begin
					if (scl_rise) begin
						next_bitcnt = 4'h0;
						next_state  = sda ? csr_pkg::CSR_SKIP : csr_pkg::CSR_ACK;
						next_after_ack = csr_pkg::CSR_RDATA;
					end
				end
			endcase
		end
		// Register pointer auto-increments after each written byte
		if (wr_en)
			next_ptr = ptr + 8'h01;
	end

	always_ff @(posedge REF_CLK_I) begin
		if (!RST_N_I) begin
			state     <= csr_pkg::CSR_IDLE;
			after_ack <= csr_pkg::CSR_IDLE;
			bitcnt    <= 4'h0;
			shreg     <= 8'h00;
			ptr       <= 8'h00;
			sda_oe    <= 1'b0;
			wr_en     <= 1'b0;
		end else begin
			state     <= next_state;
			after_ack <= next_after_ack;
			bitcnt    <= next_bitcnt;
			shreg     <= next_shreg;
			ptr       <= next_ptr;
			sda_oe    <= next_sda_oe;
			wr_en     <= next_wr_en;
		end
	end

	// Open drain: only ever pull low
	assign bus.wr_en = wr_en;
	assign bus.addr  = ptr;
	assign bus.wdata = shreg;
	assign SDA_O     = 1'b0;
	assign SDA_OE_O  = sda_oe;

	// Setpoint decode registered so charger loops see glitch-free values
	logic [19:0] fast_ua;
	assign fast_ua = csr_current(fast, pchg[7]);
	always_ff @(posedge REF_CLK_I) begin
		if (!RST_N_I) begin
			CHARGE_TARGET_VOLTAGE_MV_O    <= 16'h0000;
			PROGRAMMED_FAST_CURRENT_UA_O  <= 20'h00000;
			PRECHARGE_CURRENT_UA_O        <= 20'h00000;
			TERMINATION_PERCENT_CODE_O    <= 5'h00;
			TERMINATION_CURRENT_UA_X100_O <= 28'h0000000;
			TERMINATION_ENABLE_O          <= 1'b0;
			PRECHARGE_EXIT_MV_O           <= 16'h0000;
			OVERCURRENT_LIMIT_MA_O        <= 16'h0000;
			OVERCURRENT_ENABLE_O          <= 1'b0;
			UNDERVOLT_MV_O                <= 16'h0000;
			UNDERVOLT_ENABLE_O            <= 1'b0;
		end else begin
			CHARGE_TARGET_VOLTAGE_MV_O   <= `CSR_VBAT_BASE_MV +
				16'(vbat[6:0]) * `CSR_VBAT_STEP_MV;
			PROGRAMMED_FAST_CURRENT_UA_O <= fast_ua;
			PRECHARGE_CURRENT_UA_O       <= csr_current({3'h0, pchg[4:0]}, pchg[7]);
			// Code zero is forbidden to the host, so no guard here
			TERMINATION_PERCENT_CODE_O    <= term[5:1];
			TERMINATION_CURRENT_UA_X100_O <= 28'(fast_ua) * 28'(term[5:1]);
			TERMINATION_ENABLE_O          <= ~term[0];
			PRECHARGE_EXIT_MV_O <= prot[5] ? `CSR_LOWV_28_MV : `CSR_LOWV_30_MV;
			OVERCURRENT_ENABLE_O   <= ~prot[4];
			OVERCURRENT_LIMIT_MA_O <= prot[3] ? `CSR_OCP_1500_MA : `CSR_OCP_1200_MA;
			UNDERVOLT_ENABLE_O <= (prot[2:0] != 3'h7);
			unique case (prot[2:0])
				3'h3:    UNDERVOLT_MV_O <= `CSR_UV_28_MV;
				3'h4:    UNDERVOLT_MV_O <= `CSR_UV_26_MV;
				3'h5:    UNDERVOLT_MV_O <= `CSR_UV_24_MV;
				3'h6:    UNDERVOLT_MV_O <= `CSR_UV_22_MV;
				3'h7:    UNDERVOLT_MV_O <= 16'h0000;
				default: UNDERVOLT_MV_O <= `CSR_UV_30_MV;
			endcase
		end
	end
endmodule
`default_nettype wire

// [tb/csr_setpoints_asserts.sv]
`timescale 1ns/100ps
`default_nettype none
`include "csr_regs.svh"
module csr_setpoints_asserts (
	input wire logic        REF_CLK_I,
	input wire logic        RST_N_I,
	input wire logic [15:0] CHARGE_TARGET_VOLTAGE_MV_O,
	input wire logic [19:0] PROGRAMMED_FAST_CURRENT_UA_O,
	input wire logic [19:0] PRECHARGE_CURRENT_UA_O,
	input wire logic [4:0]  TERMINATION_PERCENT_CODE_O,
	input wire logic [27:0] TERMINATION_CURRENT_UA_X100_O,
	input wire logic [15:0] PRECHARGE_EXIT_MV_O,
	input wire logic [15:0] OVERCURRENT_LIMIT_MA_O,
	input wire logic        OVERCURRENT_ENABLE_O,
	input wire logic [15:0] UNDERVOLT_MV_O,
	input wire logic        UNDERVOLT_ENABLE_O
);
	wire logic [15:0] v = CHARGE_TARGET_VOLTAGE_MV_O;
	wire logic [19:0] f = PROGRAMMED_FAST_CURRENT_UA_O;
	wire logic [19:0] p = PRECHARGE_CURRENT_UA_O;
	default clocking cb @(posedge REF_CLK_I);
	endclocking
	// Outputs read zero in reset, so every check waits one sampled high edge
	default disable iff (!RST_N_I);
	volt_limits_a: assert property (
		$past(RST_N_I) |-> v >= `CSR_VBAT_BASE_MV && v <= `CSR_VBAT_MAX_MV && v % 16'hA == 16'h0)
		else $error("voltage setpoint off grid");
	fast_grid_a: assert property (
		$past(RST_N_I) |-> f % `CSR_STEP_LO_UA == 20'h0 && f <= 20'h9BA3C)
		else $error("fast current off grid");
	step_pair_a: assert property (
		$past(RST_N_I) && f % `CSR_STEP_HI_UA != 20'h0 |-> p <= 20'h0975E)
		else $error("step select not shared");
	pre_grid_a: assert property (
		$past(RST_N_I) |-> p % `CSR_STEP_LO_UA == 20'h0 && p <= 20'h12EBC)
		else $error("precharge current off grid");
	term_scale_a: assert property (
		$past(RST_N_I) |-> TERMINATION_CURRENT_UA_X100_O == 28'(f) * 28'(TERMINATION_PERCENT_CODE_O))
		else $error("termination current not scaled");
	exit_pick_a: assert property (
		$past(RST_N_I) |-> PRECHARGE_EXIT_MV_O inside {`CSR_LOWV_30_MV, `CSR_LOWV_28_MV})
		else $error("precharge exit level illegal");
	ocp_pick_a: assert property (
		$past(RST_N_I) && OVERCURRENT_ENABLE_O |-> OVERCURRENT_LIMIT_MA_O inside {16'h4B0, 16'h5DC})
		else $error("overcurrent level illegal");
	uv_pick_a: assert property (
		$past(RST_N_I) |-> UNDERVOLT_ENABLE_O == (UNDERVOLT_MV_O != 16'h0) && UNDERVOLT_MV_O
			inside {16'h0, 16'hBB8, 16'hAF0, 16'hA28, 16'h960, 16'h898})
		else $error("undervolt level illegal");
	reset_load_a: assert property (
		$rose(RST_N_I) |-> ##[1:2] (v == 16'h1068 && f == 20'h02710 && p == 20'h009C4))
		else $error("reset setpoints wrong");
endmodule
`default_nettype wire

// [tb/csr_host_model.sv]
`timescale 1ns/100ps
`default_nettype none
`include "csr_regs.svh"
module csr_host_model (
	input  wire logic clk_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_low_o
);
	// Six cycles a phase keeps clear of the four-cycle minimum
	localparam int Q = 6;
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	task automatic wt();
		repeat (Q) @(posedge clk_i);
		#1;
	endtask
	task automatic cond(input logic start);
		scl_o = 1'b0;
		sda_low_o = ~start;
		wt();
		scl_o = 1'b1;
		wt();
		sda_low_o = start;
		wt();
		if (start) begin
			scl_o = 1'b0;
			wt();
		end
	endtask
	// A one in o releases the line, so the same task reads and acks
	task automatic nine(input logic [8:0] o, output logic [8:0] s);
		for (int i = 8; i >= 0; i--) begin
			sda_low_o = ~o[i];
			wt();
			scl_o = 1'b1;
			wt();
			s[i] = sda_i;
			scl_o = 1'b0;
			wt();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
		logic [8:0] s0, s1, s2;
		cond(1'b1);
		nine({`CSR_DEV_ADDR, 1'b0, 1'b1}, s0);
		nine({a, 1'b1}, s1);
		nine({d, 1'b1}, s2);
		cond(1'b0);
		ok = !s0[0] && !s1[0] && !s2[0];
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		logic [8:0] s0, s1, s2, s3;
		cond(1'b1);
		nine({`CSR_DEV_ADDR, 1'b0, 1'b1}, s0);
		nine({a, 1'b1}, s1);
		cond(1'b1);
		nine({`CSR_DEV_ADDR, 1'b1, 1'b1}, s2);
		nine(9'h1FF, s3);
		cond(1'b0);
		d = s3[8:1];
	endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic        clk, rst_n, scl, host_low, sda_o, sda_oe, ten, oce, uve;
	logic [4:0]  pct;
	logic [15:0] volt, pexit, ocp, uv;
	logic [19:0] fast, pre;
	logic [27:0] tcur;
	logic [7:0]  sh [5];
	logic [7:0]  rst_v [5] = '{8'h3C, 8'h08, 8'h02, 8'h14, 8'h00};
	logic [31:0] uvt [8] = '{32'hBB8, 32'hBB8, 32'hBB8, 32'hAF0, 32'hA28, 32'h960, 32'h898, 32'h0};
	int          fails = 0;
	int          samples_checked = 0;
	int          cyc = 0;
	wire logic   sda = ~(host_low | (sda_oe & ~sda_o));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	csr_setpoints DUT (
		.REF_CLK_I(clk), .RST_N_I(rst_n), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o),
		.SDA_OE_O(sda_oe), .CHARGE_TARGET_VOLTAGE_MV_O(volt),
		.PROGRAMMED_FAST_CURRENT_UA_O(fast), .PRECHARGE_CURRENT_UA_O(pre),
		.TERMINATION_PERCENT_CODE_O(pct), .TERMINATION_CURRENT_UA_X100_O(tcur),
		.TERMINATION_ENABLE_O(ten), .PRECHARGE_EXIT_MV_O(pexit),
		.OVERCURRENT_LIMIT_MA_O(ocp), .OVERCURRENT_ENABLE_O(oce),
		.UNDERVOLT_MV_O(uv), .UNDERVOLT_ENABLE_O(uve)
	);
	csr_host_model host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(host_low));
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			fails++;
			report_and_stop();
		end
	end
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic check_all();
		logic [31:0] st;
		st = sh[2][7] ? 32'h9C4 : 32'h4E2;
		chk("volt", 32'(volt), 32'hE10 + 32'(sh[0][6:0]) * 32'hA);
		chk("fast", 32'(fast), 32'(sh[1]) * st);
		chk("pre", 32'(pre), 32'(sh[2][4:0]) * st);
		chk("pct", 32'(pct), 32'(sh[3][5:1]));
		chk("term", 32'(tcur), 32'(sh[1]) * st * 32'(sh[3][5:1]));
		chk("ten", 32'(ten), {31'h0, ~sh[3][0]});
		chk("exit", 32'(pexit), sh[4][5] ? 32'hAF0 : 32'hBB8);
		chk("ocen", 32'(oce), {31'h0, ~sh[4][4]});
		if (!sh[4][4]) chk("ocp", 32'(ocp), sh[4][3] ? 32'h5DC : 32'h4B0);
		chk("uv", 32'(uv), uvt[sh[4][2:0]]);
		chk("uven", 32'(uve), 32'(sh[4][2:0] != 3'h7));
	endtask
	task automatic rdk(input int i);
		logic [7:0] d;
		host.rd(8'h12 + 8'(i), d);
		chk("reg", 32'(d), 32'(sh[i]));
		check_all();
	endtask
	task automatic wrk(input int i, input logic [7:0] d);
		logic ok;
		host.wr(8'h12 + 8'(i), d, ok);
		chk("ack", 32'(ok), 32'h1);
		// Saturation keeps the spare top bit as written
		sh[i] = (i == 0 && d[6:0] > 7'h64) ? {d[7], 7'h64} : d;
		rdk(i);
	endtask
	// An unmapped offset is acked, reads zero and disturbs no stored bit
	task automatic spare_chk();
		logic [7:0] d;
		logic       ok;
		host.wr(8'h17, 8'hFF, ok);
		chk("spare ack", 32'(ok), 32'h1);
		host.rd(8'h17, d);
		chk("spare", 32'(d), 32'h0);
		check_all();
	endtask
	task automatic do_reset();
		rst_n = 1'b0;
		repeat (8) @(posedge clk);
		#1;
		rst_n = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		sh = rst_v;
		for (int i = 0; i < 5; i++) rdk(i);
	endtask
	task automatic report_and_stop();
		if (fails == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		do_reset();
		wrk(0, 8'h64);
		wrk(0, 8'hFF);
		wrk(0, 8'h00);
		wrk(1, 8'hFF);
		wrk(2, 8'hFF);
		wrk(1, 8'h81);
		wrk(2, 8'h1F);
		wrk(3, 8'hFF);
		wrk(3, 8'h02);
		for (int i = 0; i < 8; i++) wrk(4, {2'b10, i[0], i[1:0], i[2:0]});
		spare_chk();
		do_reset();
		report_and_stop();
	end
endmodule
bind csr_setpoints csr_setpoints_asserts u_chk (
	.REF_CLK_I, .RST_N_I, .CHARGE_TARGET_VOLTAGE_MV_O, .PROGRAMMED_FAST_CURRENT_UA_O,
	.PRECHARGE_CURRENT_UA_O, .TERMINATION_PERCENT_CODE_O, .TERMINATION_CURRENT_UA_X100_O,
	.PRECHARGE_EXIT_MV_O, .OVERCURRENT_LIMIT_MA_O, .OVERCURRENT_ENABLE_O, .UNDERVOLT_MV_O,
	.UNDERVOLT_ENABLE_O
);
`default_nettype wire
